// ---- pkg/crb_pkg.sv ----
package crb_pkg;
   // Internal data area geometry
   localparam int AREA_BYTES = 512;
   localparam int RAM_BYTES = 256;
   localparam int RAM_WORDS = RAM_BYTES / 2;
   localparam int BASE_GRAN_BITS = 12; // 4 K placement boundary
   localparam int NUM_BANKS = 8;
   localparam int BANK_WORDS = RAM_WORDS / NUM_BANKS; // 16 words each
   // Word slots inside a bank
   localparam logic [3:0] SLOT_ACC = 4'h0;
   localparam logic [3:0] SLOT_BASE = 4'h1;
   localparam logic [3:0] SLOT_COUNT = 4'h2;
   localparam logic [3:0] SLOT_DATA = 4'h3;
   localparam logic [3:0] SLOT_SP = 4'h4;
   localparam logic [3:0] SLOT_FRAME = 4'h5;
   localparam logic [3:0] SLOT_SRC = 4'h6;
   localparam logic [3:0] SLOT_DST = 4'h7;
   localparam logic [3:0] SLOT_PSEG = 4'h8;
   localparam logic [3:0] SLOT_SSEG = 4'h9;
   localparam logic [3:0] SLOT_DSEG0 = 4'hA;
   localparam logic [3:0] SLOT_DSEG1 = 4'hB;
   localparam logic [3:0] SLOT_VPC = 4'hC;
   localparam logic [3:0] SLOT_PSW_SAVE = 4'hD;
   localparam logic [3:0] SLOT_PC_SAVE = 4'hE;
   // Reset values
   localparam logic [15:0] PSW_RESET = 16'hF002;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] PSEG_RESET = 16'hFFFF;
   localparam logic [15:0] SEG_RESET = 16'h0000;
   localparam logic [15:0] LOOP_RESET = 16'h0000;
   localparam logic [19:0] BASE_RESET = 20'hFF000;
   localparam logic [2:0] RESET_BANK = 3'h7;
   // Status word field positions
   localparam int PSW_ONE_BIT = 15;
   localparam int PSW_BANK_HI = 14;
   localparam int PSW_BANK_LO = 12;
   localparam int PSW_UF1_BIT = 5;
   localparam int PSW_UF0_BIT = 3;
   localparam int PSW_IOTRAP_BIT = 1;
   // Segment select codes
   typedef enum logic [1:0] {
      CRB_SEG_DATA0 = 2'h0,
      CRB_SEG_DATA1 = 2'h1,
      CRB_SEG_PROG = 2'h2,
      CRB_SEG_STACK = 2'h3
   } crb_seg_t;
   // Offset source codes
   typedef enum logic [1:0] {
      CRB_OFS_PC = 2'h0,
      CRB_OFS_SP = 2'h1,
      CRB_OFS_SRC = 2'h2,
      CRB_OFS_DST = 2'h3
   } crb_ofs_t;
   // Bank switch causes
   typedef enum logic [2:0] {
      CRB_SW_TASK = 3'h0,
      CRB_SW_SOFT_CS = 3'h1,
      CRB_SW_MOVE_A = 3'h2,
      CRB_SW_MOVE_B = 3'h3,
      CRB_SW_IRQ = 3'h4
   } crb_cause_t;
   // Switch sequencer states
   typedef enum logic [3:0] {
      CRB_ST_IDLE = 4'b0001,
      CRB_ST_SAVE_PC = 4'b0010,
      CRB_ST_SAVE_PSW = 4'b0100,
      CRB_ST_LOAD_PC = 4'b1000
   } crb_state_t;
endpackage

// ---- design/crb_bank_ram.sv ----
module crb_bank_ram
   import crb_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic wr_en, // Write strobe
   input wire logic [6:0] wr_addr, // Word address
   input wire logic [1:0] wr_be, // Byte enables, bit 1 high byte
   input wire logic [15:0] wr_data, // Write data
   input wire logic [6:0] rd_addr_a, // Port A word address
   output logic [15:0] rd_data_a, // Port A data, combinational
   input wire logic [6:0] rd_addr_b, // Port B word address
   output logic [15:0] rd_data_b // Port B data, combinational
);
   // 256-byte internal RAM holding all eight banks
   logic [15:0] mem [RAM_WORDS];

   // Byte lanes written independently for byte registers
   always_ff @(posedge clk) begin
      if (wr_en && wr_be[0]) begin
         mem[wr_addr][7:0] <= wr_data[7:0];
      end
      if (wr_en && wr_be[1]) begin
         mem[wr_addr][15:8] <= wr_data[15:8];
      end
   end

   // Asynchronous reads keep the sequencer one cycle per step
   assign rd_data_a = mem[rd_addr_a];
   assign rd_data_b = mem[rd_addr_b];
endmodule // crb_bank_ram

// ---- design/crb_addr_gen.sv ----
module crb_addr_gen
   import crb_pkg::*;
(
   input wire logic [15:0] segment, // Selected segment value
   input wire logic [15:0] offset, // Effective offset
   output logic [19:0] phys // 20-bit physical address
);
   // Segment times 16 plus offset, wraps inside 1 MB
   assign phys = {segment, 4'h0} + {4'h0, offset};
endmodule // crb_addr_gen

// ---- design/crb_regfile.sv ----
// Contract
// - All registers and RAM sit in one 512-byte area, addressed by offset; here the upper half only reads back the two user flags.
// - Area holds 256-byte RAM that stores the register banks.
// - Area base is programmable, placed only on 4 K boundaries.
// - Eight banks, active one picked by status word bank field.
// - Bank seven is active during and right after reset.
// - Task, soft context switch, stack moves or interrupts switch banks.
// - Switch loads program counter from new bank's vector field.
// - Switch saves prior program counter and status word into bank.
// - Switch changes only bank field; return restores saved status word.
// - Four general words also accessible as high and low bytes.
// - Physical address is segment shifted left four plus offset.
// - Default segments: PC program, SP stack, indexes data zero and one.
// - Reset sets program segment all ones, other segments zero.
// - Program counter increments per fetched instruction, loads on branches.
// - Reset clears the program counter.
// - Status word bit layout from constant one down to carry.
// - Low status byte copies to accumulator high byte and back.
// - Only bank switches and bank or interrupt returns alter the bank field.
// - Reset loads status word with F002.
// - User flags also reachable through the peripheral flag register.
// - Sixteen-bit loop counter counts string and shift iterations.
module crb_regfile
   import crb_pkg::*;
(
   input wire logic MCLK, // Core clock
   input wire logic SYS_RST, // Synchronous reset, high
   input wire logic AREA_WR, // Area write strobe
   input wire logic [8:0] AREA_ADDR, // Byte offset into data area
   input wire logic [1:0] AREA_BE, // Byte enables
   input wire logic [15:0] AREA_WDATA, // Area write data
   output logic [15:0] AREA_RDATA, // Area read data, combinational
   input wire logic [19:0] PHYS_ADDR, // Address to test for area hit
   output logic AREA_HIT, // Address falls in data area
   input wire logic BASE_WR, // Write base register
   input wire logic [7:0] BASE_WDATA, // New base, 4 K granule number
   output logic [19:0] AREA_BASE, // Current base address
   input wire logic SWITCH_REQ, // Bank switch request, pulse
   input wire logic [2:0] SWITCH_CAUSE, // Cause code
   input wire logic [2:0] SWITCH_BANK, // Target bank
   output logic SWITCH_BUSY, // Switch sequence running
   input wire logic RET_REQ, // Bank or interrupt return, pulse
   input wire logic [15:0] RET_PSW, // Status word to restore
   input wire logic [15:0] RET_PC, // Program counter to restore
   input wire logic PSW_WR, // Status word write
   input wire logic [15:0] PSW_WDATA, // Status word write data
   input wire logic PSW_TO_ACC_HI, // Copy status low byte to acc high
   input wire logic ACC_HI_TO_PSW, // Restore status low byte from acc
   input wire logic FLAG_WR, // Peripheral flag register write
   input wire logic [1:0] FLAG_WDATA, // {user_flag_one, user_flag_zero}
   output logic [1:0] FLAG_RDATA, // User flags readback
   output logic [15:0] PROGRAM_STATUS_WORD, // Program status word
   input wire logic PC_INC, // Instruction taken from queue
   input wire logic PC_LOAD, // Branch, call, return or break
   input wire logic [15:0] PC_WDATA, // New program counter
   output logic [15:0] PC, // Program counter
   input wire logic LOOP_LOAD, // Load loop counter
   input wire logic [15:0] LOOP_WDATA, // Loop counter value
   input wire logic LOOP_DEC, // One iteration or shift done
   output logic [15:0] LOOP_CNT, // Loop counter
   output logic LOOP_ZERO, // Loop counter at zero
   input wire logic [1:0] SEG_SEL, // Segment override code
   input wire logic [1:0] OFS_SEL, // Offset source code
   input wire logic USE_DEFAULT, // Use default segment pairing
   input wire logic [15:0] EA, // Effective address offset
   input wire logic USE_EA, // Offset from EA, not pointer
   output logic [19:0] PHYS_OUT // Generated physical address
);
   crb_state_t state;
   logic [2:0] bank;
   logic [2:0] next_bank;
   logic [15:0] pc_before;
   logic [15:0] psw_before;
   logic [6:0] ram_wa;
   logic [15:0] ram_wd;
   logic [1:0] ram_be;
   logic ram_we;
   logic [6:0] rd_a;
   logic [6:0] rd_b;
   logic [15:0] rdat_a;
   logic [15:0] rdat_b;
   logic [15:0] seg_val;
   logic [15:0] ofs_val;
   logic [19:0] phys_raw;

   // Word address of a slot in a bank
   function automatic logic [6:0] slot_addr(input logic [2:0] b,
                                            input logic [3:0] s);
      slot_addr = {b, s};
   endfunction

   assign bank = PROGRAM_STATUS_WORD[PSW_BANK_HI:PSW_BANK_LO];
   assign SWITCH_BUSY = (state != CRB_ST_IDLE);

   // Base register, granule aligned so low 12 bits stay zero
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         AREA_BASE <= BASE_RESET;
      end else if (BASE_WR) begin
         AREA_BASE <= {BASE_WDATA, 12'h000};
      end
   end

   // Area is 512 bytes from base; the low half holds the RAM
   assign AREA_HIT = (PHYS_ADDR[19:9] == AREA_BASE[19:9]);

   // Bank switch sequencer: save PC, save PROGRAM_STATUS_WORD, load vector PC
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         state <= CRB_ST_IDLE;
         next_bank <= RESET_BANK;
         pc_before <= PC_RESET;
         psw_before <= PSW_RESET;
      end else begin
         unique case (state)
            CRB_ST_IDLE: begin
               if (SWITCH_REQ) begin
                  next_bank <= SWITCH_BANK;
                  pc_before <= PC;
                  psw_before <= PROGRAM_STATUS_WORD;
                  state <= CRB_ST_SAVE_PC;
               end
            end
            CRB_ST_SAVE_PC: state <= CRB_ST_SAVE_PSW;
            CRB_ST_SAVE_PSW: state <= CRB_ST_LOAD_PC;
            CRB_ST_LOAD_PC: state <= CRB_ST_IDLE;
            default: state <= CRB_ST_IDLE;
         endcase
      end
   end

   // RAM port mux: sequencer saves take the write port over software
   always_comb begin
      ram_we = 1'b0;
      ram_wa = 7'h00;
      ram_wd = 16'h0000;
      ram_be = 2'b11;
      if (state == CRB_ST_SAVE_PC) begin
         ram_we = 1'b1;
         ram_wa = slot_addr(next_bank, SLOT_PC_SAVE);
         ram_wd = pc_before;
      end else if (state == CRB_ST_SAVE_PSW) begin
         ram_we = 1'b1;
         ram_wa = slot_addr(next_bank, SLOT_PSW_SAVE);
         ram_wd = psw_before;
      end else if (PSW_TO_ACC_HI) begin
         ram_we = 1'b1;
         ram_wa = slot_addr(bank, SLOT_ACC);
         ram_be = 2'b10;
         ram_wd = {PROGRAM_STATUS_WORD[7:0], 8'h00};
      end else if (AREA_WR && !AREA_ADDR[8]) begin
         ram_we = 1'b1;
         ram_wa = AREA_ADDR[7:1];
         ram_be = AREA_BE;
         ram_wd = AREA_WDATA;
      end
   end

   // Read ports: A serves area reads and vector PC, B serves segments
   assign rd_a = (state == CRB_ST_LOAD_PC) ?
                 slot_addr(next_bank, SLOT_VPC) : AREA_ADDR[7:1];

   crb_bank_ram u_ram (
      .clk(MCLK),
      .wr_en(ram_we),
      .wr_addr(ram_wa),
      .wr_be(ram_be),
      .wr_data(ram_wd),
      .rd_addr_a(rd_a),
      .rd_data_a(rdat_a),
      .rd_addr_b(rd_b),
      .rd_data_b(rdat_b)
   );

   // Upper area half: reads back only the two user flags
   always_comb begin
      if (!AREA_ADDR[8]) begin
         AREA_RDATA = rdat_a;
      end else begin
         AREA_RDATA = {14'h0000, PROGRAM_STATUS_WORD[PSW_UF1_BIT], PROGRAM_STATUS_WORD[PSW_UF0_BIT]};
      end
   end
   assign FLAG_RDATA = {PROGRAM_STATUS_WORD[PSW_UF1_BIT], PROGRAM_STATUS_WORD[PSW_UF0_BIT]};

   // Status word: bank field only via switch or return
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         PROGRAM_STATUS_WORD <= PSW_RESET;
      end else if (RET_REQ && state == CRB_ST_IDLE) begin
         PROGRAM_STATUS_WORD <= RET_PSW | 16'h8000;
      end else if (state == CRB_ST_SAVE_PC) begin
         PROGRAM_STATUS_WORD[PSW_BANK_HI:PSW_BANK_LO] <= next_bank;
      end else if (PSW_WR) begin
         // Bit 15 forced, bank bits kept: software cannot move banks
         PROGRAM_STATUS_WORD <= {1'b1, PROGRAM_STATUS_WORD[PSW_BANK_HI:PSW_BANK_LO],
                 PSW_WDATA[11:0]};
      end else if (ACC_HI_TO_PSW) begin
         PROGRAM_STATUS_WORD[7:0] <= rdat_b[15:8];
      end else if (FLAG_WR) begin
         PROGRAM_STATUS_WORD[PSW_UF1_BIT] <= FLAG_WDATA[1];
         PROGRAM_STATUS_WORD[PSW_UF0_BIT] <= FLAG_WDATA[0];
      end
   end

   // Program counter
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         PC <= PC_RESET;
      end else if (state == CRB_ST_LOAD_PC) begin
         PC <= rdat_a;
      end else if (RET_REQ && state == CRB_ST_IDLE) begin
         PC <= RET_PC;
      end else if (PC_LOAD) begin
         PC <= PC_WDATA;
      end else if (PC_INC && state == CRB_ST_IDLE) begin
         PC <= PC + 16'h0001;
      end
   end
   // Loop counter, stops at zero
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         LOOP_CNT <= LOOP_RESET;
      end else if (LOOP_LOAD) begin
         LOOP_CNT <= LOOP_WDATA;
      end else if (LOOP_DEC && LOOP_CNT != 16'h0000) begin
         LOOP_CNT <= LOOP_CNT - 16'h0001;
      end
   end
   assign LOOP_ZERO = (LOOP_CNT == 16'h0000);

   // Reset values stand until the bank seven slot is written
   logic [3:0] seg_written;
   crb_seg_t seg_code;
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         seg_written <= 4'h0;
      end else if (ram_we && ram_wa[6:2] == {RESET_BANK, 2'b10}) begin
         seg_written[ram_wa[1:0]] <= 1'b1;
      end
   end
   // Default pairing, else explicit override
   always_comb begin
      if (USE_DEFAULT) begin
         unique case (crb_ofs_t'(OFS_SEL))
            CRB_OFS_PC: seg_code = CRB_SEG_PROG;
            CRB_OFS_SP: seg_code = CRB_SEG_STACK;
            CRB_OFS_SRC: seg_code = CRB_SEG_DATA0;
            CRB_OFS_DST: seg_code = CRB_SEG_DATA1;
         endcase
      end else begin
         seg_code = crb_seg_t'(SEG_SEL);
      end
   end
   // Segment slots sit at 8..B; a status restore borrows the port
   always_comb begin
      unique case (seg_code)
         CRB_SEG_PROG: rd_b = slot_addr(bank, SLOT_PSEG);
         CRB_SEG_STACK: rd_b = slot_addr(bank, SLOT_SSEG);
         CRB_SEG_DATA0: rd_b = slot_addr(bank, SLOT_DSEG0);
         CRB_SEG_DATA1: rd_b = slot_addr(bank, SLOT_DSEG1);
      endcase
      if (ACC_HI_TO_PSW) begin
         rd_b = slot_addr(bank, SLOT_ACC);
      end
   end
   // Other banks have no reset image, so they always read RAM
   always_comb begin
      if (bank != RESET_BANK || seg_written[rd_b[1:0]]) begin
         seg_val = rdat_b;
      end else if (seg_code == CRB_SEG_PROG) begin
         seg_val = PSEG_RESET;
      end else begin
         seg_val = SEG_RESET;
      end
   end
   // Offset source; pointer offsets come in through EA for now
   always_comb begin
      if (USE_EA) begin
         ofs_val = EA;
      end else begin
         unique case (crb_ofs_t'(OFS_SEL))
            CRB_OFS_PC: ofs_val = PC;
            CRB_OFS_SP: ofs_val = 16'h0000;
            CRB_OFS_SRC: ofs_val = 16'h0000;
            CRB_OFS_DST: ofs_val = 16'h0000;
         endcase
      end
   end

   crb_addr_gen u_agen (
      .segment(seg_val),
      .offset(ofs_val),
      .phys(phys_raw)
   );
   assign PHYS_OUT = phys_raw;
   // Checks
   reset_bank_a: assert property (@(posedge MCLK)
      SYS_RST |=> bank == RESET_BANK)
      else $error("bank not seven after reset");
   reset_psw_a: assert property (@(posedge MCLK)
      SYS_RST |=> PROGRAM_STATUS_WORD == 16'hF002 && PC == 16'h0000)
      else $error("bad status or pc reset");
   psw_top_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      PROGRAM_STATUS_WORD[15])
      else $error("status bit 15 low");
   switch_vec_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      state == CRB_ST_LOAD_PC |=> PC == $past(rdat_a))
      else $error("vector pc not loaded");
   switch_bank_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (SWITCH_REQ && state == CRB_ST_IDLE) |=> ##1
      bank == $past(SWITCH_BANK, 2))
      else $error("bank not switched");
   bank_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (PSW_WR && !RET_REQ && state == CRB_ST_IDLE)
      |=> $stable(bank))
      else $error("software moved bank");
   pc_inc_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (PC_INC && !PC_LOAD && !RET_REQ && state == CRB_ST_IDLE)
      |=> PC == $past(PC) + 16'h0001)
      else $error("pc not incremented");
   loop_dec_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (LOOP_DEC && !LOOP_LOAD && LOOP_CNT != 16'h0000)
      |=> LOOP_CNT == $past(LOOP_CNT) - 16'h0001)
      else $error("loop counter wrong");
   base_align_a: assert property (@(posedge MCLK)
      AREA_BASE[11:0] == 12'h000)
      else $error("base misaligned");
   phys_a: assert property (@(posedge MCLK)
      PHYS_OUT == {seg_val, 4'h0} + {4'h0, ofs_val})
      else $error("physical address wrong");
   switch_c: cover property (@(posedge MCLK)
      state == CRB_ST_IDLE ##1 state == CRB_ST_SAVE_PC ##3
      state == CRB_ST_IDLE);
   ret_c: cover property (@(posedge MCLK) RET_REQ && !SYS_RST);
   flag_c: cover property (@(posedge MCLK) FLAG_WR && !SYS_RST);
endmodule // crb_regfile

// ---- dv/crb_seq_model.sv ----
module crb_seq_model (
   input wire logic mclk, // Core clock
   input wire logic busy, // Switch sequence running
   output logic sw_req, // Bank switch request
   output logic [2:0] sw_cause, // Cause of the switch
   output logic [2:0] sw_bank, // Target bank
   output logic ret_req, // Bank or interrupt return
   output logic [15:0] ret_psw, // Status word to restore
   output logic [15:0] ret_pc // Program counter to restore
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet at time zero
   initial begin
      {sw_req, ret_req, sw_cause, sw_bank, ret_psw, ret_pc} = '0;
   end
   // Busy is sampled at the falling edge, so a free sequencer takes it
   task automatic hold_until_taken;
      while (busy) @(negedge mclk);
      @(negedge mclk);
   endtask
   // Switch by any documented cause; fields scrambled once released
   task automatic switch_to(input logic [2:0] cause, input logic [2:0] bank);
      @(negedge mclk);
      sw_req = 1'b1;
      sw_cause = cause;
      sw_bank = bank;
      hold_until_taken;
      sw_req = 1'b0;
      sw_cause = ~cause;
      sw_bank = ~bank;
   endtask
   // Return is the only path that moves the bank field back
   task automatic ret_to(input logic [15:0] p, input logic [15:0] c);
      @(negedge mclk);
      ret_req = 1'b1;
      ret_psw = p | 16'h8000;
      ret_pc = c;
      hold_until_taken;
      ret_req = 1'b0;
      ret_psw = ~ret_psw;
      ret_pc = ~c;
   endtask
endmodule // crb_seq_model

// ---- dv/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, sys_rst, area_wr, base_wr, psw_wr, st_to_acc, acc_to_st;
   logic flag_wr, pc_inc, pc_load, loop_load, loop_dec, use_def, use_ea;
   logic sw_req, ret_req, busy, hit, loop_zero;
   logic [1:0] area_be, flag_wdata, flag_rd, seg_sel, ofs_sel;
   logic [2:0] sw_cause, sw_bank;
   logic [7:0] base_wdata;
   logic [8:0] area_addr;
   logic [15:0] area_wdata, rdata, ret_psw, ret_pc, psw_wdata, program_status_word, pc;
   logic [15:0] pc_wdata, loop_wdata, loop_cnt, ea, p, v;
   logic [19:0] phys_addr, base, phys;
   logic [19:0] hp [4] = '{20'h12000, 20'h121FF, 20'h12200, 20'h11FFF};
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   // Core clock, 10 ns
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   crb_regfile dut (.MCLK(mclk), .SYS_RST(sys_rst), .AREA_WR(area_wr),
      .AREA_ADDR(area_addr), .AREA_BE(area_be), .AREA_WDATA(area_wdata),
      .AREA_RDATA(rdata), .PHYS_ADDR(phys_addr), .AREA_HIT(hit),
      .BASE_WR(base_wr), .BASE_WDATA(base_wdata), .AREA_BASE(base),
      .SWITCH_REQ(sw_req), .SWITCH_CAUSE(sw_cause), .SWITCH_BANK(sw_bank),
      .SWITCH_BUSY(busy), .RET_REQ(ret_req), .RET_PSW(ret_psw),
      .RET_PC(ret_pc), .PSW_WR(psw_wr), .PSW_WDATA(psw_wdata),
      .PSW_TO_ACC_HI(st_to_acc), .ACC_HI_TO_PSW(acc_to_st),
      .FLAG_WR(flag_wr),
      .FLAG_WDATA(flag_wdata), .FLAG_RDATA(flag_rd), .PROGRAM_STATUS_WORD(program_status_word),
      .PC_INC(pc_inc), .PC_LOAD(pc_load), .PC_WDATA(pc_wdata), .PC(pc),
      .LOOP_LOAD(loop_load), .LOOP_WDATA(loop_wdata), .LOOP_DEC(loop_dec),
      .LOOP_CNT(loop_cnt), .LOOP_ZERO(loop_zero), .SEG_SEL(seg_sel),
      .OFS_SEL(ofs_sel),
      .USE_DEFAULT(use_def), .EA(ea), .USE_EA(use_ea), .PHYS_OUT(phys));
   crb_seq_model sq (.mclk(mclk), .busy(busy), .sw_req(sw_req),
      .sw_cause(sw_cause), .sw_bank(sw_bank), .ret_req(ret_req),
      .ret_psw(ret_psw), .ret_pc(ret_pc));
   task check(input logic [19:0] seen, input logic [19:0] exp);
      n_checks++;
      if (seen !== exp) begin
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
         n_errors++;
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Strobes last exactly one rising edge
   task step;
      @(negedge mclk);
      {area_wr, base_wr, psw_wr, st_to_acc, acc_to_st, flag_wr} = '0;
      {pc_inc, pc_load, loop_load, loop_dec} = '0;
   endtask
   task automatic wr(input logic [8:0] a, input logic [1:0] be,
      input logic [15:0] d);
      @(negedge mclk);
      area_wr = 1'b1;
      area_addr = a;
      area_be = be;
      area_wdata = d;
      step;
   endtask
   task automatic rd(input logic [8:0] a);
      @(negedge mclk);
      area_addr = a;
      #1 v = rdata;
   endtask
   // Hang guard, far above the hundred or so cycles needed
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         complete_run;
      end
   end
   // Main sequence
   initial begin
      {area_wr, base_wr, psw_wr, st_to_acc, acc_to_st, flag_wr} = '0;
      {pc_inc, pc_load, loop_load, loop_dec, use_def, use_ea} = '0;
      {area_addr, area_be, area_wdata, phys_addr, base_wdata} = '0;
      {psw_wdata, flag_wdata, pc_wdata, loop_wdata, seg_sel, ofs_sel} = '0;
      ea = '0;
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      check(program_status_word[14:12], 3'h7);
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      check(program_status_word, 16'hF002);
      check(pc, 16'h0000);
      check(loop_cnt, 16'h0000);
      check(base, 20'hFF000);
      use_def = 1'b1;
      #1 check(phys, 20'hFFFF0);
      $display("test reset done");
      // Byte lanes of the accumulator, then segment pairing with wrap
      wr(9'h0E0, 2'h3, 16'h1234);
      wr(9'h0E0, 2'h1, 16'hFFAB);
      rd(9'h0E0);
      check(v, 16'h12AB);
      wr(9'h0F6, 2'h3, 16'hFFFF);
      use_ea = 1'b1;
      ea = 16'h0020;
      seg_sel = 2'h0;
      for (int k = 0; k < 4; k++) begin
         ofs_sel = k[1:0];
         #1 check(phys, (k == 1 || k == 2) ? 20'h00020 : 20'h00010);
      end
      use_def = 1'b0;
      seg_sel = 2'h1;
      #1 check(phys, 20'h00010);
      {use_def, use_ea} = 2'b10;
      $display("test lanes done");
      // Status word writes, byte copy and peripheral flags
      @(negedge mclk);
      psw_wr = 1'b1;
      psw_wdata = 16'h8ABC;
      step;
      check(program_status_word, 16'hFABC);
      @(negedge mclk);
      st_to_acc = 1'b1;
      step;
      rd(9'h0E0);
      check(v, 16'hBCAB);
      wr(9'h0E0, 2'h2, 16'h5A00);
      @(negedge mclk);
      acc_to_st = 1'b1;
      step;
      check(program_status_word, 16'hFA5A);
      for (int k = 0; k < 2; k++) begin
         @(negedge mclk);
         flag_wr = 1'b1;
         flag_wdata = k ? 2'h3 : 2'h0;
         step;
         check(flag_rd, k ? 2'h3 : 2'h0);
         check(program_status_word, k ? 16'hFA7A : 16'hFA52);
      end
      $display("test status done");
      // Area base placement and hit window
      @(negedge mclk);
      base_wr = 1'b1;
      base_wdata = 8'h12;
      step;
      check(base, 20'h12000);
      for (int k = 0; k < 4; k++) begin
         phys_addr = hp[k];
         #1 check(hit, k < 2);
      end
      // Program and loop counters, back-to-back counts
      @(negedge mclk);
      pc_load = 1'b1;
      pc_wdata = 16'h0100;
      step;
      pc_inc = 1'b1;
      @(negedge mclk);
      step;
      check(pc, 16'h0102);
      @(negedge mclk);
      loop_load = 1'b1;
      loop_wdata = 16'h0003;
      step;
      loop_dec = 1'b1;
      repeat (2) @(negedge mclk);
      step;
      check(loop_cnt, 16'h0000);
      check(loop_zero, 1'b1);
      $display("test counters done");
      // Switch for every cause, check saves, then return
      for (int c = 0; c < 5; c++) begin
         p = program_status_word;
         wr(9'(c * 32 + 24), 2'h3, 16'h4000 + 16'(c));
         sq.switch_to(3'(c), 3'(c));
         for (int i = 0; i < 10 && busy; i++) @(negedge mclk);
         check(busy, 1'b0);
         check(program_status_word, {p[15], 3'(c), p[11:0]});
         check(pc, 16'h4000 + 16'(c));
         rd(9'(c * 32 + 28));
         check(v, 16'h0102);
         rd(9'(c * 32 + 26));
         check(v, p);
         sq.ret_to(p, 16'h0102);
         check(program_status_word, p);
         check(pc, 16'h0102);
      end
      $display("test switch done");
      // Mid-run restart drops the written segment back to zero
      ofs_sel = 2'h3;
      #1 check(phys, 20'hFFFF0);
      @(negedge mclk);
      sys_rst = 1'b1;
      @(negedge mclk);
      sys_rst = 1'b0;
      check(program_status_word, 16'hF002);
      check(pc, 16'h0000);
      check(base, 20'hFF000);
      #1 check(phys, 20'h00000);
      $display("test restart done");
      complete_run;
   end
endmodule // testbench
